// ===== verification/flash_dev_model.sv
// Behavioural flash device seen through the controller pins
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model
    import flash_guard_pkg::*;
(
    input wire flash_guard_pkg::flash_out_s pins,
    output logic [15:0] dq
);
    logic sec = 1'b0;
    logic [15:0] rd;
    logic [15:0] last = 16'h0;
    // Mode flag from enter and exit words, cleared by reset pin
    always @(posedge pins.we_n or negedge pins.reset_n) begin
        if (!pins.reset_n) begin
            sec <= 1'b0;
        end else if (!pins.ce_n && pins.oe_n) begin
            if (pins.dq_out == 16'h0088) sec <= 1'b1;
            if (pins.dq_out == 16'h0090) sec <= 1'b0;
        end
    end
    // Secured words differ from array words at the same address
    assign rd = pins.addr[15:0] ^ (sec ? 16'h5A5A : 16'h0000);
    always @* if (!pins.ce_n && !pins.oe_n) last = rd;
    // Released bus shows the inverse of the last word
    assign dq = (!pins.ce_n && !pins.oe_n) ? rd : ~last;
endmodule
`default_nettype wire

// ===== verification/tb_flash_guard_host.sv
// Register-level bench of the flash protection host controller
`timescale 1ns/10ps
`default_nettype none
module tb_flash_guard_host;
    import flash_guard_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [1:0] bresp, rresp, r;
    logic [15:0] dq;
    flash_out_s flash_pins;
    int miscompares = 0, num_checks = 0, cyc = 0;
    logic [31:0] tc [4] = '{32'h1, 32'h5, 32'h4, 32'h3};
    logic [31:0] ta [4] = '{32'h1000, 32'h1FF000, 32'h1FF000, 32'h1000};
    logic [31:0] ts [4] = '{32'h8, 32'h8, 32'h0, 32'h8};
    always #5 ref_clk = ~ref_clk;
    flash_guard_host #(.ENTER_SEQ('{3{'{21'h555, 16'h0088}}}),
        .EXIT_SEQ('{4{'{21'h555, 16'h0090}}})) u_dut (.ref_clk(ref_clk),
        .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .flash_dq_in(dq),
        .flash_pins(flash_pins));
    flash_dev_model u_flash (.pins(flash_pins), .dq(dq));
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic tw, tb, tv;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge ref_clk);
            tw = awvalid && awready;
            tv = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge ref_clk);
            if (tw) awvalid <= 1'b0;
            if (tv) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        logic tw, tb;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge ref_clk);
            tw = arvalid && arready;
            tb = rvalid;
            v = rdata;
            r = rresp;
            @(posedge ref_clk);
            if (tw) arvalid <= 1'b0;
        end while (!tb);
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Flash operation, then poll until the engine is idle
    task automatic op(input op_e o, input logic [31:0] a);
        wr(OFS_ADDR, a);
        wr(OFS_CMD, {29'h0, o});
        do rd(OFS_STATUS); while (v[ST_BUSY] !== 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_STATUS);
        chk(v, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, tc[i]);
            op(OP_WRITE, ta[i]);
            chk(v, ts[i]);
            chk(32'({flash_pins.hv_reset_en,
                !flash_pins.write_protect_accel_pin}), tc[i] & 32'h3);
            wr(OFS_STATUS, 32'h8);
        end
        wr(OFS_CTRL, 32'h0);
        op(OP_ENTER, 32'h0);
        chk(v, 32'h2);
        op(OP_READ, 32'h123);
        rd(OFS_RDATA);
        chk(v, 32'h5B79);
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CTRL, 32'(6 * m));
            op(OP_SERIAL, 32'h0);
            for (int i = 0; i < 8; i++) begin
                rd(OFS_SN_BASE + 8'(4 * i));
                chk(v, (32'h8000 * m) ^ 32'h5A5A ^ i);
            end
        end
        wr(OFS_CTRL, 32'h0);
        op(OP_EXIT, 32'h0);
        op(OP_READ, 32'h123);
        rd(OFS_RDATA);
        chk(v, 32'h123);
        op(OP_ENTER, 32'h0);
        op(OP_RESET, 32'h0);
        chk(v, 32'h0);
        op(OP_INDICATOR, 32'h80);
        chk(v, 32'h4);
        op(OP_ENTER, 32'h0);
        op(OP_READ, 32'h9000);
        chk(v, 32'hE);
        wr(OFS_STATUS, 32'h8);
        op(OP_WRITE, 32'h100);
        chk(v, 32'hE);
        rd(8'hF0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'hF0, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wrap_up();
    end
endmodule
`default_nettype wire

// ===== verilog/flash_guard_host.sv
// Host controller driving flash protection and secured region pins
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module flash_guard_host #(
    parameter flash_guard_pkg::bus_step_s [flash_guard_pkg::ENTER_LEN-1:0]
        ENTER_SEQ = '0,
    parameter flash_guard_pkg::bus_step_s [flash_guard_pkg::EXIT_LEN-1:0]
        EXIT_SEQ = '0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [flash_guard_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [flash_guard_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [flash_guard_pkg::DATA_W-1:0] flash_dq_in,
    output flash_guard_pkg::flash_out_s flash_pins
);
    import flash_guard_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_W_SETUP, S_W_PULSE, S_W_HOLD, S_R_PULSE, S_R_SAMPLE, S_RST
    } state_e;

    state_e state, next_state;
    op_e op, next_op, cmd_op;
    logic [STEP_W-1:0] step, next_step;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic secured, next_secured, factory_locked, next_factory;
    logic refused, next_refused;
    logic [DATA_W-1:0] rd_data, next_rd_data, dq_meta, dq_sync;
    flash_out_s next_pins;
    bus_step_s cur;
    logic [2:0] ctrl, next_ctrl;
    logic [ADDR_W-1:0] addr_reg, next_addr_reg;
    logic [DATA_W-1:0] wdata_reg, next_wdata_reg;
    logic aw_hold, next_aw_hold, w_hold, next_w_hold, rd_pend, next_rd_pend;
    logic [AXI_AW-1:0] awaddr_q, next_awaddr_q, raddr_q, next_raddr_q;
    logic [31:0] wdata_q, next_wdata_q, next_rdata;
    logic [3:0] wstrb_q, next_wstrb_q;
    logic [1:0] next_bresp, next_rresp;
    logic next_bvalid, next_rvalid, cmd_go, clr_refused;
    logic busy, in_outer, in_window, refuse, sn_wr;
    logic [DATA_W-1:0] sn_rd;
    logic [31:0] status_word;

    // Byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Last step index of each operation
    function automatic logic [STEP_W-1:0] last_of(input op_e o);
        unique case (o)
            OP_ENTER: return STEP_W'(ENTER_LEN - 1);
            OP_EXIT: return STEP_W'(EXIT_LEN - 1);
            OP_SERIAL: return STEP_W'(SN_WORDS - 1);
            default: return '0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dq_meta <= '0;
            dq_sync <= '0;
        end else begin
            dq_meta <= flash_dq_in;
            dq_sync <= dq_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address classification of the pending command
    assign busy = (state != S_IDLE);
    assign cmd_op = op_e'(wdata_q[2:0]);
    assign in_outer = ctrl[CTRL_TOP] ? (addr_reg >= OUTER_TOP_BASE)
                                     : (addr_reg < OUTER_SPAN);
    assign in_window = ctrl[CTRL_TOP] ? (addr_reg >= SEC_TOP_BASE)
                                      : (addr_reg < SEC_SPAN);
    // Host-side refusal of commands the device would reject
    assign refuse = (cmd_op > OP_INDICATOR)
        || (cmd_op == OP_WRITE && ctrl[CTRL_WP_LOW] && in_outer
            && !secured)
        || (cmd_op == OP_WRITE && secured && factory_locked)
        || ((cmd_op == OP_WRITE || cmd_op == OP_READ) && secured
            && !in_window);
    assign sn_wr = (state == S_R_SAMPLE) && (op == OP_SERIAL);

    // Address and data of the current bus step
    always_comb begin
        cur.addr = addr_reg;
        cur.data = wdata_reg;
        unique case (next_op)
            OP_ENTER: cur = ENTER_SEQ[next_step[1:0]];
            OP_EXIT: cur = EXIT_SEQ[next_step[1:0]];
            OP_SERIAL: cur.addr = (ctrl[CTRL_TOP] ? SEC_TOP_BASE
                : SN_BOTTOM_BASE) + ADDR_W'(next_step);
            default: cur.addr = addr_reg;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle engine, next values
    always_comb begin
        next_state = state;
        next_op = op;
        next_step = step;
        next_cnt = cnt;
        next_secured = secured;
        next_factory = factory_locked;
        next_refused = refused;
        next_rd_data = rd_data;
        if (clr_refused) begin
            next_refused = 1'b0;
        end
        unique case (state)
            S_IDLE: begin
                if (cmd_go) begin
                    next_step = '0;
                    if (refuse) begin
                        next_refused = 1'b1;
                    end else if (cmd_op == OP_RESET) begin
                        next_op = cmd_op;
                        next_state = S_RST;
                        next_cnt = CNT_W'(RST_CYC - 1);
                    end else if (cmd_op == OP_WRITE || cmd_op == OP_ENTER
                                 || cmd_op == OP_EXIT) begin
                        next_op = cmd_op;
                        next_state = S_W_SETUP;
                    end else begin
                        next_op = cmd_op;
                        next_state = S_R_PULSE;
                        next_cnt = CNT_W'(READ_CYC + SYNC_CYC - 1);
                    end
                end
            end
            S_W_SETUP: begin
                next_state = S_W_PULSE;
                next_cnt = CNT_W'(WE_CYC - 1);
            end
            S_W_PULSE: begin
                if (cnt == '0) begin
                    next_state = S_W_HOLD;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            S_W_HOLD: begin
                if (step == last_of(op)) begin
                    next_state = S_IDLE;
                    if (op == OP_ENTER) begin
                        next_secured = 1'b1;
                    end else if (op == OP_EXIT) begin
                        next_secured = 1'b0;
                    end
                end else begin
                    next_step = step + 1'b1;
                    next_state = S_W_SETUP;
                end
            end
            S_R_PULSE: begin
                if (cnt == '0) begin
                    next_state = S_R_SAMPLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            S_R_SAMPLE: begin
                next_rd_data = dq_sync;
                if (op == OP_INDICATOR) begin
                    next_factory = dq_sync[DQ7_BIT];
                end
                if (step == last_of(op)) begin
                    next_state = S_IDLE;
                end else begin
                    next_step = step + 1'b1;
                    next_state = S_R_PULSE;
                    next_cnt = CNT_W'(READ_CYC + SYNC_CYC - 1);
                end
            end
            S_RST: begin
                if (cnt == '0) begin
                    next_state = S_IDLE;
                    next_secured = 1'b0;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
        endcase
        // Pin levels that belong to the next state
        next_pins = PINS_IDLE;
        next_pins.hv_reset_en = ctrl[CTRL_HV];
        next_pins.write_protect_accel_pin = !ctrl[CTRL_WP_LOW];
        next_pins.addr = cur.addr;
        next_pins.dq_out = cur.data;
        unique case (next_state)
            S_W_SETUP, S_W_HOLD: begin
                next_pins.ce_n = 1'b0;
                next_pins.dq_oe_n = 1'b0;
            end
            S_W_PULSE: begin
                next_pins.ce_n = 1'b0;
                next_pins.we_n = 1'b0;
                next_pins.dq_oe_n = 1'b0;
            end
            S_R_PULSE, S_R_SAMPLE: begin
                next_pins.ce_n = 1'b0;
                next_pins.oe_n = 1'b0;
            end
            S_RST: begin
                next_pins.reset_n = 1'b0;
                next_pins.hv_reset_en = 1'b0;
            end
            S_IDLE: begin
                next_pins.ce_n = 1'b1;
            end
        endcase
    end

    // Bus cycle engine registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            op <= OP_READ;
            step <= '0;
            cnt <= '0;
            secured <= 1'b0;
            factory_locked <= 1'b0;
            refused <= 1'b0;
            rd_data <= '0;
            flash_pins <= PINS_IDLE;
        end else begin
            state <= next_state;
            op <= next_op;
            step <= next_step;
            cnt <= next_cnt;
            secured <= next_secured;
            factory_locked <= next_factory;
            refused <= next_refused;
            rd_data <= next_rd_data;
            flash_pins <= next_pins;
        end
    end

    sn_store u_sn_store (
        .ref_clk(ref_clk),
        .wr_en(sn_wr),
        .wr_addr(step),
        .wr_data(dq_sync),
        .rd_addr(araddr[4:2]),
        .rd_data(sn_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave, next values
    assign awready = !aw_hold && !bvalid;
    assign wready = !w_hold && !bvalid;
    assign arready = !rd_pend && !rvalid;
    assign status_word = {28'h0000000, refused, factory_locked, secured,
                          busy};

    always_comb begin
        next_aw_hold = aw_hold;
        next_w_hold = w_hold;
        next_awaddr_q = awaddr_q;
        next_wdata_q = wdata_q;
        next_wstrb_q = wstrb_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_ctrl = ctrl;
        next_addr_reg = addr_reg;
        next_wdata_reg = wdata_reg;
        next_rd_pend = rd_pend;
        next_raddr_q = raddr_q;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        cmd_go = 1'b0;
        clr_refused = 1'b0;
        if (awvalid && awready) begin
            next_aw_hold = 1'b1;
            next_awaddr_q = awaddr;
        end
        if (wvalid && wready) begin
            next_w_hold = 1'b1;
            next_wdata_q = wdata;
            next_wstrb_q = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        // Both halves held: perform the write
        if (aw_hold && w_hold) begin
            next_aw_hold = 1'b0;
            next_w_hold = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            unique case (awaddr_q)
                OFS_CTRL: next_ctrl = 3'(merge(32'(ctrl), wdata_q, wstrb_q));
                OFS_ADDR: next_addr_reg =
                    ADDR_W'(merge(32'(addr_reg), wdata_q, wstrb_q));
                OFS_WDATA: next_wdata_reg =
                    DATA_W'(merge(32'(wdata_reg), wdata_q, wstrb_q));
                OFS_CMD: begin
                    if (busy) begin
                        next_bresp = RESP_SLVERR;
                    end else begin
                        cmd_go = 1'b1;
                    end
                end
                OFS_STATUS: clr_refused = wdata_q[ST_REFUSED] && wstrb_q[0];
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rd_pend = 1'b1;
            next_raddr_q = araddr;
        end
        // Read answer one cycle after the address is taken
        if (rd_pend) begin
            next_rd_pend = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            if ((raddr_q & OFS_SN_MASK) == OFS_SN_BASE) begin
                next_rdata = 32'(sn_rd);
            end else begin
                unique case (raddr_q)
                    OFS_CTRL: next_rdata = 32'(ctrl);
                    OFS_ADDR: next_rdata = 32'(addr_reg);
                    OFS_WDATA: next_rdata = 32'(wdata_reg);
                    OFS_STATUS: next_rdata = status_word;
                    OFS_RDATA: next_rdata = 32'(rd_data);
                    default: begin
                        next_rdata = '0;
                        next_rresp = RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // AXI4-Lite slave registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            ctrl <= CTRL_RESET;
            addr_reg <= '0;
            wdata_reg <= '0;
            rd_pend <= 1'b0;
            raddr_q <= '0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            aw_hold <= next_aw_hold;
            w_hold <= next_w_hold;
            awaddr_q <= next_awaddr_q;
            wdata_q <= next_wdata_q;
            wstrb_q <= next_wstrb_q;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            ctrl <= next_ctrl;
            addr_reg <= next_addr_reg;
            wdata_reg <= next_wdata_reg;
            rd_pend <= next_rd_pend;
            raddr_q <= next_raddr_q;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the pins and the engine
    sequence s_we_pulse;
        (!flash_pins.we_n && !flash_pins.ce_n)[*4] ##1 flash_pins.we_n;
    endsequence

    a_we_gating: assert property (@(posedge ref_clk) disable iff (rst)
        !flash_pins.we_n |-> !flash_pins.ce_n && flash_pins.oe_n)
        else $error("write strobe low without chip-select or with oe low");
    a_we_pulse_width: assert property (@(posedge ref_clk)
        disable iff (rst) $fell(flash_pins.we_n) |-> s_we_pulse)
        else $error("write strobe pulse not four cycles");
    a_enter_sets_mode: assert property (@(posedge ref_clk)
        disable iff (rst) (state == S_W_HOLD && op == OP_ENTER
        && step == 3'h2) |=> secured)
        else $error("enter sequence did not set secured mode");
    a_exit_clears_mode: assert property (@(posedge ref_clk)
        disable iff (rst) (state == S_W_HOLD && op == OP_EXIT
        && step == 3'h3) |=> !secured && state == S_IDLE)
        else $error("exit sequence did not clear secured mode");
    a_reset_clears_mode: assert property (@(posedge ref_clk)
        disable iff (rst) (state == S_RST && cnt == '0) |=> !secured)
        else $error("hardware reset left secured mode set");
    a_outer_refused: assert property (@(posedge ref_clk)
        disable iff (rst) (state == S_IDLE && cmd_go && cmd_op == OP_WRITE
        && ctrl[CTRL_WP_LOW] && in_outer && !secured)
        |=> refused && state == S_IDLE ##1 flash_pins.we_n)
        else $error("outer boot write not refused");
    a_factory_refused: assert property (@(posedge ref_clk)
        disable iff (rst) (state == S_IDLE && cmd_go && cmd_op == OP_WRITE
        && secured && factory_locked) |=> state == S_IDLE)
        else $error("write to factory locked region started");
    a_indicator_latch: assert property (@(posedge ref_clk)
        disable iff (rst) (state == S_R_SAMPLE && op == OP_INDICATOR)
        |=> factory_locked == $past(dq_sync[DQ7_BIT]))
        else $error("lock indicator not captured from bit seven");
    a_serial_base: assert property (@(posedge ref_clk)
        disable iff (rst) (state == S_R_PULSE && op == OP_SERIAL
        && ctrl[CTRL_TOP] && $stable(ctrl))
        |-> flash_pins.addr == SEC_TOP_BASE + ADDR_W'(step))
        else $error("serial number read at wrong top-boot address");
    a_hv_reset_high: assert property (@(posedge ref_clk)
        disable iff (rst) flash_pins.hv_reset_en |-> flash_pins.reset_n)
        else $error("high voltage requested during reset pulse");
endmodule
`default_nettype wire

// ===== verilog/flash_guard_pkg.sv
// Shared constants and types of the flash protection host controller
package flash_guard_pkg;
    // Flash geometry, word addressing
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int CNT_W = 8;
    localparam int STEP_W = 3;
    localparam logic [ADDR_W-1:0] OUTER_SPAN = 21'h002000;
    localparam logic [ADDR_W-1:0] OUTER_TOP_BASE = 21'h1FE000;
    localparam logic [ADDR_W-1:0] SEC_SPAN = 21'h008000;
    localparam logic [ADDR_W-1:0] SEC_TOP_BASE = 21'h1F8000;
    localparam logic [ADDR_W-1:0] SN_BOTTOM_BASE = 21'h000000;
    localparam int SN_WORDS = 8;
    localparam int ENTER_LEN = 3;
    localparam int EXIT_LEN = 4;
    localparam int DQ7_BIT = 7;

    // Register map, byte offsets on the AXI4-Lite port
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_ADDR = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_WDATA = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_CMD = 8'h0C;
    localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h10;
    localparam logic [AXI_AW-1:0] OFS_RDATA = 8'h14;
    localparam logic [AXI_AW-1:0] OFS_SN_BASE = 8'h20;
    localparam logic [AXI_AW-1:0] OFS_SN_MASK = 8'hE0;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int CTRL_WP_LOW = 0;
    localparam int CTRL_HV = 1;
    localparam int CTRL_TOP = 2;
    localparam int ST_BUSY = 0;
    localparam int ST_SECURED = 1;
    localparam int ST_FACTORY = 2;
    localparam int ST_REFUSED = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing at 100 MHz
    localparam int CLK_NS = 10;
    localparam int T_WE_PULSE_NS = 35;
    localparam int T_ACCESS_NS = 70;
    localparam int T_RESET_LOW_NS = 500;
    localparam int SYNC_CYC = 2;
    localparam int WE_CYC = (T_WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CYC = (T_RESET_LOW_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_ENTER, OP_EXIT, OP_SERIAL, OP_RESET,
        OP_INDICATOR
    } op_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bus_step_s;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
        logic hv_reset_en;
        logic write_protect_accel_pin;
        logic dq_oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
    } flash_out_s;

    localparam flash_out_s PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1,
        we_n: 1'b1, reset_n: 1'b1, hv_reset_en: 1'b0,
        write_protect_accel_pin: 1'b1, dq_oe_n: 1'b1,
        addr: '0, dq_out: '0};
endpackage

// ===== verilog/sn_store.sv
// Serial number word store with registered read data
`timescale 1ns/10ps
`default_nettype none
module sn_store (
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [2:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [15:0] mem [8];

    // Write port and registered read port
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire
